// ---- rtl/eic_cfg.svh ----
// constants of the edge interrupt controller: offsets, positions, resets
`ifndef EIC_CFG_SVH
`define EIC_CFG_SVH

// ==========================================================
// register byte offsets
`define EIC_ADDR_WIDTH 8
`define EIC_OFF_ENABLE 8'h00
`define EIC_OFF_POLARITY 8'h04
`define EIC_OFF_ROUTE 8'h08
`define EIC_OFF_PENDING 8'h0c
`define EIC_OFF_FAST 8'h10
`define EIC_OFF_NORMAL 8'h14
`define EIC_OFF_CLEAR 8'h18
`define EIC_OFF_LEVEL 8'h1c

// ==========================================================
// reset values
`define EIC_RST_ENABLE 32'h00000000
`define EIC_RST_POLARITY 32'h00000000
`define EIC_RST_ROUTE 32'h00000000
`define EIC_RST_PENDING 32'h00000000

// ==========================================================
// source map
`define EIC_MASK_VALID 32'h1dffffbf
`define EIC_MASK_EXTERNAL 32'h1ce20080
`define EIC_MASK_INTERNAL 32'h011dff3f
`define EIC_BIT_TIMER_A 0
`define EIC_BIT_TIMER_B 1
`define EIC_BIT_DATA_BAUD 2
`define EIC_BIT_DEBUG_BAUD 3
`define EIC_BIT_RTC_ALARM 4
`define EIC_BIT_SMART_CARD 5
`define EIC_BIT_DMA_BASE 8
`define EIC_BIT_SIGNAL_PROC 13
`define EIC_BIT_DATA_TX 14
`define EIC_BIT_DATA_RX_START 15
`define EIC_BIT_DATA_RX 16
`define EIC_BIT_DEBUG_TX 18
`define EIC_BIT_AUTOBAUD 19
`define EIC_BIT_DEBUG_RX 20
`define EIC_BIT_KEYPAD 24
`define EIC_GPIO_LINES 8
`define EIC_DMA_CHANNELS 5
`define EIC_SYNC_FILL 2'h3

`endif

// ---- rtl/eic_edge_detect.sv ----
// pin synchroniser and polarity-selected edge detector for port b lines
`include "eic_cfg.svh"

module eic_edge_detect #(parameter int WIDTH = 8)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link to the controller
	eic_edge_if.detector link
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] settled;
	logic [1:0] fill;
	logic [WIDTH-1:0] next_settled;
	logic [WIDTH-1:0] risen;
	logic [WIDTH-1:0] fallen;
	logic filled;

	// a line counts as changed only once stages two and three agree
	assign next_settled = (stage2 & stage3) | (settled & (stage2 | stage3));
	assign filled = (fill == `EIC_SYNC_FILL);
	assign risen = next_settled & ~settled;
	assign fallen = ~next_settled & settled;
	assign link.edgeEvent = filled ?
		((fallen & link.fallingSelect) | (risen & ~link.fallingSelect)) :
		'0;
	assign link.lineLevel = settled;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			settled <= '0;
			fill <= 2'h0;
		end
		else if (link.clockEnable)
		begin
			stage1 <= link.rawLine;
			stage2 <= stage1;
			stage3 <= stage2;
			// until the chain is full the settled level is loaded silently
			settled <= filled ? next_settled : stage2;
			fill <= filled ? fill : fill + 2'h1;
		end
	end
endmodule

// ---- rtl/eic_edge_if.sv ----
// carrier between the controller and its pin edge detector
interface eic_edge_if #(parameter int WIDTH = 8);
	logic clockEnable;
	logic [WIDTH-1:0] rawLine;
	logic [WIDTH-1:0] fallingSelect;
	logic [WIDTH-1:0] edgeEvent;
	logic [WIDTH-1:0] lineLevel;

	modport detector (
		input clockEnable,
		input rawLine,
		input fallingSelect,
		output edgeEvent,
		output lineLevel
	);
	modport controller (
		output clockEnable,
		output rawLine,
		output fallingSelect,
		input edgeEvent,
		input lineLevel
	);
endinterface

// ---- rtl/eic_pkg.sv ----
// types and source-map helpers of the edge interrupt controller
package eic_pkg;
	typedef logic [31:0] eic_word_type;

	// bit position of each port b line in the source map
	function automatic int eicGpioPos(input int line);
		case (line)
			0: eicGpioPos = 17;
			1: eicGpioPos = 27;
			2: eicGpioPos = 7;
			3: eicGpioPos = 21;
			4: eicGpioPos = 23;
			5: eicGpioPos = 22;
			6: eicGpioPos = 28;
			default: eicGpioPos = 26;
		endcase
	endfunction
endpackage

// ---- rtl/eic_top.sv ----
// edge interrupt controller: source map, pending flags, routing, apb
// Operation
// - polarity one falling edge, zero rising edge
// - polarity ignored for internal sources
// - all registers share pending bit positions
// - fast status is pending, enabled, routed fast
// - normal status is pending, enabled, routed normal
// - bits zero to five timers, baud, alarm, card
// - bits eight to twelve dma channels
// - fixed bits for dsp, serial, autobaud, keypad
// - port b lines at their fixed bits
// - pending holds until cleared, internal ones also until source gone
// - route bit one fast, zero normal
// - enable bit gates source onto chosen request
`include "eic_cfg.svh"

module eic_top
	import eic_pkg::*;
(
	// clock, reset and freeze
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clockEnable,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`EIC_ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// internal sources, same clock, active high level
	input wire logic timerA,
	input wire logic timerB,
	input wire logic dataPortBaudGenerator,
	input wire logic debugPortBaudGenerator,
	input wire logic rtcAlarm,
	input wire logic smartCardInterface,
	input wire logic [`EIC_DMA_CHANNELS-1:0] dmaChannel,
	input wire logic signalProcessor,
	input wire logic dataPortTransmit,
	input wire logic dataPortReceiveStart,
	input wire logic dataPortReceive,
	input wire logic debugTransmit,
	input wire logic autobaud,
	input wire logic debugReceive,
	input wire logic keypadPressed,
	// external port b pins, asynchronous
	input wire logic [`EIC_GPIO_LINES-1:0] gpioPortB,
	// requests to the processor core
	output logic fastRequest,
	output logic normalRequest,
	output logic interruptRequest
);
	// ==========================================================
	// helpers

	// status of one request line from pending, enable and route
	function automatic eic_word_type requestStatus(
		input eic_word_type pend,
		input eic_word_type en,
		input eic_word_type route,
		input logic wantFast
	);
		eic_word_type chosen;
		chosen = wantFast ? route : ~route;
		requestStatus = pend & en & chosen & `EIC_MASK_VALID;
	endfunction

	// one-hot style address match of a register offset
	function automatic logic hit(
		input logic [`EIC_ADDR_WIDTH-1:0] addr,
		input logic [`EIC_ADDR_WIDTH-1:0] offset
	);
		hit = (addr == offset);
	endfunction

	// masks as vectors so that single bits can be selected
	localparam eic_word_type VALID_MASK = `EIC_MASK_VALID;
	localparam eic_word_type EXTERNAL_MASK = `EIC_MASK_EXTERNAL;

	// ==========================================================
	// registers and wires

	eic_word_type sourceEnableMask;
	eic_word_type externalEdgePolarity;
	eic_word_type fastRouteSelect;
	eic_word_type sourcePendingFlags;
	eic_word_type rawSourceLevel;
	eic_word_type next_sourcePendingFlags;
	eic_word_type internalLevel;
	eic_word_type externalEvent;
	eic_word_type sourceSet;
	eic_word_type sourceClear;
	eic_word_type fastRequestStatus;
	eic_word_type normalRequestStatus;
	eic_word_type readValue;
	eic_word_type gpioLevel;
	logic setupPhase;
	logic accessDone;
	logic writeDone;
	logic hitEnable;
	logic hitPolarity;
	logic hitRoute;
	logic hitPending;
	logic hitFast;
	logic hitNormal;
	logic hitClear;
	logic hitLevel;
	logic mapped;
	logic next_fastRequest;
	logic next_normalRequest;
	// next values of the configuration, level and answer flops
	eic_word_type next_sourceEnableMask;
	eic_word_type next_externalEdgePolarity;
	eic_word_type next_fastRouteSelect;
	eic_word_type next_rawSourceLevel;
	eic_word_type next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic loadEnable;
	logic loadPolarity;
	logic loadRoute;

	eic_edge_if #(.WIDTH(`EIC_GPIO_LINES)) edgeLink ();

	// ==========================================================
	// apb decode

	// a transfer still waiting for its answer; a freeze on the setup edge
	// lets it run on into the access phase without being lost
	assign setupPhase = psel & ~pready;
	assign accessDone = psel & penable & pready;
	assign writeDone = accessDone & pwrite;
	assign hitEnable = hit(paddr, `EIC_OFF_ENABLE);
	assign hitPolarity = hit(paddr, `EIC_OFF_POLARITY);
	assign hitRoute = hit(paddr, `EIC_OFF_ROUTE);
	assign hitPending = hit(paddr, `EIC_OFF_PENDING);
	assign hitFast = hit(paddr, `EIC_OFF_FAST);
	assign hitNormal = hit(paddr, `EIC_OFF_NORMAL);
	assign hitClear = hit(paddr, `EIC_OFF_CLEAR);
	assign hitLevel = hit(paddr, `EIC_OFF_LEVEL);
	assign mapped = hitEnable | hitPolarity | hitRoute | hitPending |
		hitFast | hitNormal | hitClear | hitLevel;

	// read mux; clear register is write only and reads zero
	always_comb
	begin
		if (hitEnable)
			readValue = sourceEnableMask;
		else if (hitPolarity)
			readValue = externalEdgePolarity;
		else if (hitRoute)
			readValue = fastRouteSelect;
		else if (hitPending)
			readValue = sourcePendingFlags;
		else if (hitFast)
			readValue = fastRequestStatus;
		else if (hitNormal)
			readValue = normalRequestStatus;
		else if (hitLevel)
			readValue = rawSourceLevel;
		else
			readValue = '0;
	end

	// ==========================================================
	// source map

	// internal sources placed at their fixed positions
	always_comb
	begin
		internalLevel = '0;
		internalLevel[`EIC_BIT_TIMER_A] = timerA;
		internalLevel[`EIC_BIT_TIMER_B] = timerB;
		internalLevel[`EIC_BIT_DATA_BAUD] = dataPortBaudGenerator;
		internalLevel[`EIC_BIT_DEBUG_BAUD] = debugPortBaudGenerator;
		internalLevel[`EIC_BIT_RTC_ALARM] = rtcAlarm;
		internalLevel[`EIC_BIT_SMART_CARD] = smartCardInterface;
		internalLevel[`EIC_BIT_DMA_BASE +: `EIC_DMA_CHANNELS] =
			dmaChannel;
		internalLevel[`EIC_BIT_SIGNAL_PROC] = signalProcessor;
		internalLevel[`EIC_BIT_DATA_TX] = dataPortTransmit;
		internalLevel[`EIC_BIT_DATA_RX_START] = dataPortReceiveStart;
		internalLevel[`EIC_BIT_DATA_RX] = dataPortReceive;
		internalLevel[`EIC_BIT_DEBUG_TX] = debugTransmit;
		internalLevel[`EIC_BIT_AUTOBAUD] = autobaud;
		internalLevel[`EIC_BIT_DEBUG_RX] = debugReceive;
		internalLevel[`EIC_BIT_KEYPAD] = keypadPressed;
	end

	// port b lines to and from their source positions; the level view
	// takes each pin after its synchroniser, never the raw pin
	genvar line;
	generate
		for (line = 0; line < `EIC_GPIO_LINES; line++)
		begin : gpioMap
			assign edgeLink.fallingSelect[line] =
				externalEdgePolarity[eicGpioPos(line)];
			assign externalEvent[eicGpioPos(line)] =
				edgeLink.edgeEvent[line];
			assign gpioLevel[eicGpioPos(line)] = edgeLink.lineLevel[line];
		end
	endgenerate

	// positions without a port b line carry no event
	generate
		for (line = 0; line < 32; line++)
		begin : gpioIdle
			if (!EXTERNAL_MASK[line])
			begin : none
				assign externalEvent[line] = 1'b0;
				assign gpioLevel[line] = 1'b0;
			end
		end
	endgenerate

	assign edgeLink.clockEnable = clockEnable;
	assign edgeLink.rawLine = gpioPortB;

	eic_edge_detect #(.WIDTH(`EIC_GPIO_LINES)) edgeDetect (
		.clk(clk),
		.rst_n(rst_n),
		.link(edgeLink)
	);

	// ==========================================================
	// pending flags

	// internal sources are detected by level, never by the polarity bits
	assign sourceSet = ((internalLevel & `EIC_MASK_INTERNAL) |
		(externalEvent & `EIC_MASK_EXTERNAL)) & `EIC_MASK_VALID;

	// a clear of an internal source only takes where its level has gone away
	assign sourceClear = (writeDone & hitClear) ?
		(pwdata & ~internalLevel) : '0;

	// set wins over a clear in the same cycle
	assign next_sourcePendingFlags =
		((sourcePendingFlags & ~sourceClear) | sourceSet) &
		`EIC_MASK_VALID;

	// level view of every source, registered once like the flags
	assign next_rawSourceLevel = (internalLevel | gpioLevel) & VALID_MASK;

	// ==========================================================
	// request status and outputs

	assign fastRequestStatus = requestStatus(sourcePendingFlags,
		sourceEnableMask, fastRouteSelect, 1'b1);
	assign normalRequestStatus = requestStatus(sourcePendingFlags,
		sourceEnableMask, fastRouteSelect, 1'b0);
	// requests follow their status one edge later
	assign next_fastRequest = |fastRequestStatus;
	assign next_normalRequest = |normalRequestStatus;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			fastRequest <= 1'b0;
			normalRequest <= 1'b0;
			interruptRequest <= 1'b0;
		end
		else if (clockEnable)
		begin
			fastRequest <= next_fastRequest;
			normalRequest <= next_normalRequest;
			interruptRequest <= next_fastRequest | next_normalRequest;
		end
	end

	// ==========================================================
	// configuration registers

	// a register loads only on the completing edge of a write to it;
	// writes to read-only or unmapped offsets load nothing
	assign loadEnable = writeDone & hitEnable;
	assign loadPolarity = writeDone & hitPolarity;
	assign loadRoute = writeDone & hitRoute;
	assign next_sourceEnableMask = loadEnable ?
		(pwdata & VALID_MASK) : sourceEnableMask;
	assign next_externalEdgePolarity = loadPolarity ?
		(pwdata & EXTERNAL_MASK) : externalEdgePolarity;
	assign next_fastRouteSelect = loadRoute ?
		(pwdata & VALID_MASK) : fastRouteSelect;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sourceEnableMask <= `EIC_RST_ENABLE;
			externalEdgePolarity <= `EIC_RST_POLARITY;
			fastRouteSelect <= `EIC_RST_ROUTE;
		end
		else if (clockEnable)
		begin
			sourceEnableMask <= next_sourceEnableMask;
			externalEdgePolarity <= next_externalEdgePolarity;
			fastRouteSelect <= next_fastRouteSelect;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sourcePendingFlags <= `EIC_RST_PENDING;
			rawSourceLevel <= '0;
		end
		else if (clockEnable)
		begin
			sourcePendingFlags <= next_sourcePendingFlags;
			rawSourceLevel <= next_rawSourceLevel;
		end
	end

	// ==========================================================
	// apb answer: ready in the cycle after setup, zero wait states

	// one answer per transfer, as a single-cycle pulse
	assign next_pready = setupPhase;
	assign next_pslverr = setupPhase & ~mapped;
	assign next_prdata = (setupPhase && !pwrite) ? readValue : '0;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (clockEnable)
		begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end
endmodule

// ---- verification/eic_core_model.sv ----
// processor core model: enters the fast handler first, else the normal one
module eic_core_model
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// requests from the controller
	input wire logic fastRequest,
	input wire logic normalRequest,
	// handler in use: 2 fast, 1 normal, 0 idle
	output logic [1:0] coreMode
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk)
		coreMode <= !rst_n ? 2'h0 :
			fastRequest ? 2'h2 : {1'b0, normalRequest};
endmodule

// ---- verification/eic_tb.sv ----
// testbench of the edge interrupt controller: apb driver and scoreboard
`include "eic_cfg.svh"

module tb
	import eic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, clockEnable, psel, penable, pwrite, pready, pslverr;
	logic fastRequest, normalRequest, interruptRequest;
	logic [`EIC_ADDR_WIDTH-1:0] paddr;
	logic [7:0] gpio;
	logic [1:0] coreMode;
	eic_word_type pwdata, prdata, src, seed, en, rt, pv, b, f, n;
	logic [32:0] q[$];
	int miscompares, check_count, cycles;
	int gp[8] = '{17, 27, 7, 21, 23, 22, 28, 26};

	eic_top i_eic_top (.clk(clk), .rst_n(rst_n), .clockEnable(clockEnable),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timerA(src[0]), .timerB(src[1]), .dataPortBaudGenerator(src[2]),
		.debugPortBaudGenerator(src[3]), .rtcAlarm(src[4]),
		.smartCardInterface(src[5]), .dmaChannel(src[12:8]),
		.signalProcessor(src[13]), .dataPortTransmit(src[14]),
		.dataPortReceiveStart(src[15]), .dataPortReceive(src[16]),
		.debugTransmit(src[18]), .autobaud(src[19]), .debugReceive(src[20]),
		.keypadPressed(src[24]), .gpioPortB(gpio), .fastRequest(fastRequest),
		.normalRequest(normalRequest), .interruptRequest(interruptRequest));
	eic_core_model i_eic_core_model (.clk(clk), .rst_n(rst_n),
		.fastRequest(fastRequest), .normalRequest(normalRequest),
		.coreMode(coreMode));

	function automatic eic_word_type rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks=%0d miscompares=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// one apb transfer; a read's expectation goes to the scoreboard first
	task automatic xfer(input logic w, input logic [7:0] a,
		input eic_word_type d, input logic [32:0] e);
		if (!w)
			q.push_back(e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		xfer(1'b0, a, 32'h0, e);
	endtask

	task automatic wr(input logic [7:0] a, input eic_word_type d);
		xfer(1'b1, a, d, 33'h0);
	endtask

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (pready === 1'b1 && !pwrite)
			check({pslverr, prdata}, q.pop_front());
		if (cycles == 20000)
		begin
			miscompares++;
			finish_test();
		end
	end

	initial
	begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, src, gpio} = '0;
		clockEnable = 1'b1;
		seed = 32'h63;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 32; a += 4)
			rd(8'(a), 33'h0);
		wr(`EIC_OFF_ENABLE, '1);
		rd(`EIC_OFF_ENABLE, `EIC_MASK_VALID);
		wr(`EIC_OFF_POLARITY, '1);
		rd(`EIC_OFF_POLARITY, `EIC_MASK_EXTERNAL);
		en = rnd();
		rt = rnd();
		wr(`EIC_OFF_ENABLE, en);
		wr(`EIC_OFF_ROUTE, rt);
		rd(`EIC_OFF_ROUTE, rt & `EIC_MASK_VALID);
		for (int i = 0; i < 32; i++)
		begin
			b = 32'h1 << i;
			if ((b & `EIC_MASK_INTERNAL) == 0)
				continue;
			f = b & en & rt;
			n = b & en & ~rt;
			src[i] <= 1'b1;
			@(posedge clk);
			src[i] <= 1'b0;
			rd(`EIC_OFF_PENDING, b);
			rd(`EIC_OFF_FAST, f);
			rd(`EIC_OFF_NORMAL, n);
			check(fastRequest, f != 0);
			check(normalRequest, n != 0);
			check(interruptRequest, (f | n) != 0);
			check(coreMode, f != 0 ? 2 : n != 0);
			wr(`EIC_OFF_CLEAR, b);
			rd(`EIC_OFF_PENDING, 33'h0);
		end
		src[0] <= 1'b1;
		wr(`EIC_OFF_CLEAR, 32'h1);
		rd(`EIC_OFF_PENDING, 33'h1);
		rd(`EIC_OFF_LEVEL, 33'h1);
		src[0] <= 1'b0;
		wr(`EIC_OFF_CLEAR, 32'h1);
		rd(`EIC_OFF_PENDING, 33'h0);
		// source off before its polarity changes
		wr(`EIC_OFF_ENABLE, 32'h0);
		pv = rnd();
		wr(`EIC_OFF_POLARITY, pv);
		for (int l = 0; l < 8; l++)
		begin
			gpio[l] <= pv[gp[l]];
			repeat (8) @(posedge clk);
			wr(`EIC_OFF_CLEAR, '1);
			gpio[l] <= !pv[gp[l]];
			repeat (8) @(posedge clk);
			rd(`EIC_OFF_PENDING, 32'h1 << gp[l]);
			wr(`EIC_OFF_CLEAR, '1);
			gpio[l] <= pv[gp[l]];
			repeat (8) @(posedge clk);
			rd(`EIC_OFF_PENDING, 33'h0);
		end
		wr(`EIC_OFF_ENABLE, en);
		rd(`EIC_OFF_ENABLE, en & `EIC_MASK_VALID);
		rd(8'h20, {1'b1, 32'h0});
		rd(8'h02, {1'b1, 32'h0});
		wr(`EIC_OFF_PENDING, '1);
		rd(`EIC_OFF_PENDING, 33'h0);
		finish_test();
	end
endmodule

// ---- verification/eic_top_properties.sv ----
// concurrent checks on the ports of the edge interrupt controller
`include "eic_cfg.svh"

module eic_top_properties
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clockEnable,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`EIC_ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// requests
	input wire logic fastRequest,
	input wire logic normalRequest,
	input wire logic interruptRequest
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// bus answer
	setup_answer_a: assert property (psel && !penable && clockEnable |=> pready)
		else $error("no answer after setup");
	answer_pulse_a: assert property (pready && clockEnable |=> !pready)
		else $error("answer longer than one cycle");
	answer_cause_a: assert property (pready |-> $past(psel && !penable))
		else $error("answer without setup");
	unaligned_err_a: assert property (psel && !penable && clockEnable
		&& paddr[1:0] != 2'h0 |=> pslverr)
		else $error("unaligned access not refused");
	mapped_ok_a: assert property (psel && !penable && clockEnable
		&& paddr < 8'h20 && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("mapped access refused");
	idle_data_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	reserved_zero_a: assert property (
		pready && !pwrite && paddr < 8'h1c
		|-> (prdata & ~`EIC_MASK_VALID) == 32'h0)
		else $error("reserved bit read as one");

	// ==========================================================
	// requests
	request_or_a: assert property (
		interruptRequest == (fastRequest || normalRequest))
		else $error("combined request mismatch");
	reset_quiet_a: assert property ($rose(rst_n) |-> !pready && !fastRequest
		&& !normalRequest && !interruptRequest)
		else $error("outputs active after reset");

	fast_seen_c: cover property ($rose(fastRequest));
	normal_seen_c: cover property ($rose(normalRequest));
	error_seen_c: cover property (pready && pslverr);
endmodule

bind eic_top eic_top_properties i_eic_top_properties (.clk(clk),
	.rst_n(rst_n), .clockEnable(clockEnable), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .fastRequest(fastRequest),
	.normalRequest(normalRequest), .interruptRequest(interruptRequest));
